// [bench/sdh_card_model.sv]
/*
 * Card-side partner: answers every block request with one done pulse
 * after LAT+1 idle cycles.
 * Assumes the same clock as the configuration block.
 */
`timescale 1ns/10ps
module sdh_card_model (
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       BLOCK_START,
	input  wire logic [7:0] LAT,
	output logic            BLOCK_DONE
);
	logic       busy_q;
	logic [7:0] wait_q;

	// ***************************************************************
	// One done pulse per block, never in the start cycle
	// ***************************************************************
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			busy_q     <= 1'b0;
			wait_q     <= 8'h00;
			BLOCK_DONE <= 1'b0;
		end else begin
			BLOCK_DONE <= 1'b0;
			if (BLOCK_START) begin
				busy_q <= 1'b1;
				wait_q <= LAT;
			end else if (busy_q && wait_q == 8'h00) begin
				BLOCK_DONE <= 1'b1;
				busy_q     <= 1'b0;
			end else if (busy_q) begin
				wait_q <= wait_q - 8'h01;
			end
		end
	end
endmodule // sdh_card_model

// [bench/testbench.sv]
/*
 * Self-checking bench for the configuration block: register model,
 * block splitter model and refusal cases.
 * Assumes the card model answers each block request.
 */
`timescale 1ns/10ps
module testbench;
	logic        CLK = 1'b0;
	logic        RST = 1'b1;
	logic [7:0]  AVS_ADDRESS = 8'h00;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0]  AVS_BYTEENABLE = 4'hF;
	logic [31:0] AVS_READDATA;
	logic        AVS_WAITREQUEST;
	logic [1:0]  AVS_RESPONSE;
	logic        BLOCK_DONE, IF_ENABLE, BUS_WIDTH_4, BLOCK_START, XFER_ACTIVE;
	logic [1:0]  TX_WIDTH, RX_WIDTH;
	logic [3:0]  BLOCK_LEN_LOG2;
	logic [7:0]  lat = 8'h00;
	logic [31:0] cfg_m = 32'h0;
	logic [31:0] rdat;
	logic [1:0]  rrsp;
	int          error_cnt = 0;
	int          compares = 0;
	int          starts = 0;
	integer      seed = 32'h5969;

	always #5 CLK = ~CLK;
	always @(posedge CLK) if (BLOCK_START === 1'b1) starts <= starts + 1;

	sdh_cfg dut (.CLK(CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.AVS_RESPONSE(AVS_RESPONSE), .BLOCK_DONE(BLOCK_DONE), .IF_ENABLE(IF_ENABLE),
		.BUS_WIDTH_4(BUS_WIDTH_4), .TX_WIDTH(TX_WIDTH), .RX_WIDTH(RX_WIDTH),
		.BLOCK_LEN_LOG2(BLOCK_LEN_LOG2), .BLOCK_START(BLOCK_START), .XFER_ACTIVE(XFER_ACTIVE));
	sdh_card_model card (.CLK(CLK), .RST(RST), .BLOCK_START(BLOCK_START), .LAT(lat),
		.BLOCK_DONE(BLOCK_DONE));

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Entered right after a rising edge; holds the request until waitrequest is seen low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [3:0] be);
		int n;
		n = 0;
		AVS_ADDRESS <= a;
		AVS_WRITE <= wr;
		AVS_READ <= ~wr;
		AVS_WRITEDATA <= d;
		AVS_BYTEENABLE <= be;
		@(posedge CLK);
		while (AVS_WAITREQUEST !== 1'b0 && n < 100) begin
			@(posedge CLK);
			n++;
		end
		if (n == 100) error_cnt++;
		rdat = AVS_READDATA;
		rrsp = AVS_RESPONSE;
		AVS_READ <= 1'b0;
		AVS_WRITE <= 1'b0;
		@(posedge CLK);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] rsp);
		bus(1'b0, a, 32'h0, 4'hF);
		chk("readdata", rdat, exp);
		chk("response", {30'h0, rrsp}, {30'h0, rsp});
	endtask

	task automatic wcfg(input logic [31:0] d, input logic [3:0] be);
		logic [31:0] m;
		m = 32'h000033EF & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		bus(1'b1, sdh_pkg::OFS_CFG, d, be);
		cfg_m = (cfg_m & ~m) | (d & m);
		chk("bus width", {31'h0, BUS_WIDTH_4}, {31'h0, cfg_m[13:12] == 2'h1});
		chk("tx width", {30'h0, TX_WIDTH}, {30'h0, cfg_m[9:8]});
		chk("rx width", {30'h0, RX_WIDTH}, {30'h0, cfg_m[7:6]});
		chk("enable", {31'h0, IF_ENABLE}, {31'h0, cfg_m[5]});
		chk("block code", {28'h0, BLOCK_LEN_LOG2}, {28'h0, cfg_m[3:0]});
		rd(sdh_pkg::OFS_CFG, cfg_m, sdh_pkg::RESP_OKAY);
	endtask

	task automatic xfer(input logic [3:0] code, input logic [31:0] cnt, input logic en,
			input logic [7:0] l);
		logic ok;
		int   n;
		ok = en && code != 4'h0 && cnt != 32'h0 && (cnt % (32'h1 << code)) == 32'h0;
		n = 0;
		lat <= l;
		bus(1'b1, sdh_pkg::OFS_STATUS, 32'hE, 4'hF);
		wcfg({18'h0, 2'h1, 2'h0, 2'h2, 2'h3, en, 1'b0, code}, 4'hF);
		starts = 0;
		bus(1'b1, sdh_pkg::OFS_COUNT, cnt, 4'hF);
		while (XFER_ACTIVE === 1'b1 && n < 5000) begin
			@(posedge CLK);
			n++;
		end
		if (n == 5000) error_cnt++;
		chk("block starts", starts, ok ? cnt >> code : 32'h0);
		rd(sdh_pkg::OFS_STATUS, ok ? 32'h2 : 32'h4, sdh_pkg::RESP_OKAY);
		if (ok) rd(sdh_pkg::OFS_REMAIN, 32'h0, sdh_pkg::RESP_OKAY);
	endtask

	task automatic conclude;
		$display("errors %0d compares %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ***************************************************************
	// Main sequence
	// ***************************************************************
	initial begin
		repeat (4) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		chk("outputs", {BLOCK_LEN_LOG2, TX_WIDTH, RX_WIDTH, BUS_WIDTH_4, IF_ENABLE}, 32'h0);
		rd(sdh_pkg::OFS_CFG, 32'h0, sdh_pkg::RESP_OKAY);
		// Every field code, with random noise in the reserved bits
		for (int i = 0; i < 16; i++) begin
			wcfg(($random(seed) & ~32'h33EF) | {18'h0, i[1:0], 2'h0, i[1:0], i[1:0], i[0],
				1'b0, i[3:0]}, 4'hF);
		end
		for (int i = 0; i < 12; i++) begin
			wcfg($random(seed), 4'($random(seed)));
		end
		rd(8'h20, 32'h0, sdh_pkg::RESP_DECERR);
		bus(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
		rd(sdh_pkg::OFS_CFG, cfg_m, sdh_pkg::RESP_OKAY);
		xfer(4'h1, 32'h8, 1'b1, 8'h00);
		xfer(4'h3, 32'h40, 1'b1, 8'h05);
		xfer(4'hF, 32'h10000, 1'b1, 8'h02);
		xfer(4'h9, 32'h200, 1'b1, 8'h01);
		xfer(4'h0, 32'h8, 1'b1, 8'h00);
		xfer(4'h2, 32'h6, 1'b1, 8'h00);
		xfer(4'h2, 32'h8, 1'b0, 8'h00);
		xfer(4'h2, 32'h0, 1'b1, 8'h00);
		// Enable dropped while the card is still busy with the first block
		lat <= 8'h1E;
		bus(1'b1, sdh_pkg::OFS_STATUS, 32'hE, 4'hF);
		wcfg(32'h00000021, 4'hF);
		bus(1'b1, sdh_pkg::OFS_COUNT, 32'h8, 4'hF);
		repeat (3) @(posedge CLK);
		wcfg(32'h00000001, 4'hF);
		chk("active", {31'h0, XFER_ACTIVE}, 32'h0);
		rd(sdh_pkg::OFS_STATUS, 32'h8, sdh_pkg::RESP_OKAY);
		conclude;
	end

	initial begin
		repeat (50000) @(posedge CLK);
		error_cnt++;
		conclude;
	end
endmodule // testbench

// [src/sdh_cfg.sv]
/*
 * Configuration register of the memory-card host with its Avalon-MM slave
 * and the block splitter that issues a transfer as block-length chunks.
 * Assumes card-side logic on the same clock answers each BLOCK_START with
 * one BLOCK_DONE pulse, and that software flushes the FIFOs itself.
 */
`timescale 1ns/10ps
module sdh_cfg (
	input  wire logic        CLK,
	input  wire logic        RST,
	input  wire logic [7:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	output logic      [1:0]  AVS_RESPONSE,
	input  wire logic        BLOCK_DONE,
	output logic             IF_ENABLE,
	output logic             BUS_WIDTH_4,
	output logic      [1:0]  TX_WIDTH,
	output logic      [1:0]  RX_WIDTH,
	output logic      [3:0]  BLOCK_LEN_LOG2,
	output logic             BLOCK_START,
	output logic             XFER_ACTIVE
);
	// ***************************************************************
	// Declarations
	// ***************************************************************
	logic                 wait_q;
	logic                 wait_d;
	logic [31:0]          rdata_q;
	logic [31:0]          rdata_d;
	logic [1:0]           resp_q;
	logic [1:0]           resp_d;
	logic [31:0]          cfg_q;
	logic [31:0]          cfg_d;
	logic [31:0]          count_q;
	logic [31:0]          count_d;
	logic                 bus4_q;
	logic                 bus4_d;
	sdh_pkg::sdh_state_type state_q;
	sdh_pkg::sdh_state_type state_d;
	logic                 start_q;
	logic                 start_d;
	logic                 active_q;
	logic                 active_d;
	logic                 done_q;
	logic                 done_d;
	logic                 err_q;
	logic                 err_d;
	logic                 abort_q;
	logic                 abort_d;
	logic                 commit_wr;
	logic                 hit_cfg;
	logic                 hit_count;
	logic                 hit_status;
	logic                 hit_remain;
	logic [31:0]          be_mask;
	logic [31:0]          wr_count;
	logic [31:0]          blk_len;
	logic                 start_ok;
	logic                 load;
	logic                 step;
	logic [31:0]          remain;
	logic                 last;
	logic [3:0]           blk_code;

	// ***************************************************************
	// Avalon-MM slave
	// ***************************************************************
	// One wait cycle on every access: the request is seen with waitrequest
	// high, the answer is latched, then waitrequest drops for one cycle.
	always_comb begin
		hit_cfg    = (AVS_ADDRESS == sdh_pkg::OFS_CFG);
		hit_count  = (AVS_ADDRESS == sdh_pkg::OFS_COUNT);
		hit_status = (AVS_ADDRESS == sdh_pkg::OFS_STATUS);
		hit_remain = (AVS_ADDRESS == sdh_pkg::OFS_REMAIN);
		commit_wr  = AVS_WRITE && !wait_q;
		be_mask    = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
			{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
		wait_d     = wait_q ? !(AVS_READ || AVS_WRITE) : 1'b1;
		rdata_d    = rdata_q;
		resp_d     = resp_q;
		if (wait_q && (AVS_READ || AVS_WRITE)) begin
			rdata_d = 32'h00000000;
			resp_d  = sdh_pkg::RESP_OKAY;
			if (!(hit_cfg || hit_count || hit_status || hit_remain)) begin
				resp_d = sdh_pkg::RESP_DECERR;
			end else if (AVS_READ) begin
				case (1'b1)
					hit_cfg: begin
						rdata_d = cfg_q & sdh_pkg::CFG_WMASK;
					end
					hit_count: begin
						rdata_d = count_q;
					end
					hit_status: begin
						rdata_d[sdh_pkg::ST_ACTIVE] = active_q;
						rdata_d[sdh_pkg::ST_DONE]   = done_q;
						rdata_d[sdh_pkg::ST_ERROR]  = err_q;
						rdata_d[sdh_pkg::ST_ABORT]  = abort_q;
					end
					default: begin
						rdata_d = remain;
					end
				endcase
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h00000000;
			resp_q  <= 2'h0;
		end else begin
			wait_q  <= wait_d;
			rdata_q <= rdata_d;
			resp_q  <= resp_d;
		end
	end

	// ***************************************************************
	// Configuration register
	// ***************************************************************
	always_comb begin
		cfg_d = cfg_q;
		if (commit_wr && hit_cfg) begin
			// Reserved positions never store a one
			cfg_d = ((cfg_q & ~be_mask) | (AVS_WRITEDATA & be_mask))
				& sdh_pkg::CFG_WMASK;
		end
		// Only code 01 widens the card bus; reserved codes stay on one line
		bus4_d = (cfg_d[sdh_pkg::BUSW_LSB +: 2] == sdh_pkg::BUSW_FOUR);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cfg_q  <= sdh_pkg::CFG_RESET;
			bus4_q <= 1'b0;
		end else begin
			cfg_q  <= cfg_d;
			bus4_q <= bus4_d;
		end
	end

	// ***************************************************************
	// Block splitter
	// ***************************************************************
	// Writing the byte count starts a transfer. The interface must be enabled, the block code non-zero,
	// and the count non-zero and whole blocks long; otherwise the start is refused and flagged.
	always_comb begin
		blk_code = cfg_q[sdh_pkg::BLK_LSB +: 4];
		blk_len  = 32'h00000001 << blk_code;
		wr_count = (count_q & ~be_mask) | (AVS_WRITEDATA & be_mask);
		start_ok = cfg_q[sdh_pkg::ENA_BIT] && (blk_code != sdh_pkg::BLK_RSVD)
			&& (wr_count != 32'h00000000)
			&& ((wr_count & (blk_len - 32'h00000001)) == 32'h00000000);
		count_d  = count_q;
		state_d  = state_q;
		load     = 1'b0;
		step     = 1'b0;
		done_d   = done_q;
		err_d    = err_q;
		abort_d  = abort_q;
		// Clear-by-one first, so a same-cycle event below wins
		if (commit_wr && hit_status) begin
			done_d  = done_q & ~AVS_WRITEDATA[sdh_pkg::ST_DONE];
			err_d   = err_q & ~AVS_WRITEDATA[sdh_pkg::ST_ERROR];
			abort_d = abort_q & ~AVS_WRITEDATA[sdh_pkg::ST_ABORT];
		end
		case (state_q)
			sdh_pkg::SDH_IDLE: begin
				if (commit_wr && hit_count) begin
					count_d = wr_count;
					if (start_ok) begin
						load    = 1'b1;
						state_d = sdh_pkg::SDH_ISSUE;
					end else begin
						err_d = 1'b1;
					end
				end
			end
			sdh_pkg::SDH_ISSUE: begin
				state_d = sdh_pkg::SDH_WAIT;
			end
			sdh_pkg::SDH_WAIT: begin
				if (BLOCK_DONE) begin
					step    = 1'b1;
					state_d = last ? sdh_pkg::SDH_IDLE : sdh_pkg::SDH_ISSUE;
					done_d  = done_d | last;
				end
			end
			default: begin
				state_d = sdh_pkg::SDH_IDLE;
			end
		endcase
		// A count write during a transfer is refused
		if (state_q != sdh_pkg::SDH_IDLE && commit_wr && hit_count) begin
			err_d = 1'b1;
		end
		// Dropping the enable stops the splitter at once
		if (state_q != sdh_pkg::SDH_IDLE && !cfg_q[sdh_pkg::ENA_BIT]) begin
			state_d = sdh_pkg::SDH_IDLE;
			step    = 1'b0;
			abort_d = 1'b1;
		end
		start_d  = (state_d == sdh_pkg::SDH_ISSUE);
		active_d = (state_d != sdh_pkg::SDH_IDLE);
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			state_q  <= sdh_pkg::SDH_IDLE;
			count_q  <= sdh_pkg::COUNT_RESET;
			start_q  <= 1'b0;
			active_q <= 1'b0;
			done_q   <= 1'b0;
			err_q    <= 1'b0;
			abort_q  <= 1'b0;
		end else begin
			state_q  <= state_d;
			count_q  <= count_d;
			start_q  <= start_d;
			active_q <= active_d;
			done_q   <= done_d;
			err_q    <= err_d;
			abort_q  <= abort_d;
		end
	end

	sdh_chunk_cnt u_chunk (
		.clk      (CLK),
		.rst      (RST),
		.load     (load),
		.load_val (wr_count),
		.step     (step),
		.blk_log2 (blk_code),
		.remain   (remain),
		.last     (last)
	);

	// ***************************************************************
	// Outputs
	// ***************************************************************
	// FIFO width selects go straight to the FIFOs; realigning their
	// pointers after a change is left to a software flush.
	assign AVS_READDATA    = rdata_q;
	assign AVS_WAITREQUEST = wait_q;
	assign AVS_RESPONSE    = resp_q;
	assign IF_ENABLE       = cfg_q[sdh_pkg::ENA_BIT];
	assign BUS_WIDTH_4     = bus4_q;
	assign TX_WIDTH        = cfg_q[sdh_pkg::TXW_LSB +: 2];
	assign RX_WIDTH        = cfg_q[sdh_pkg::RXW_LSB +: 2];
	assign BLOCK_LEN_LOG2  = cfg_q[sdh_pkg::BLK_LSB +: 4];
	assign BLOCK_START     = start_q;
	assign XFER_ACTIVE     = active_q;

	// ***************************************************************
	// Assertions
	// ***************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	sequence s_cfg_write;
		AVS_WRITE && !AVS_WAITREQUEST && hit_cfg;
	endsequence

	sequence s_last_done;
		(state_q == sdh_pkg::SDH_WAIT) && BLOCK_DONE && last && IF_ENABLE;
	endsequence

	a_bus_width: assert property ((s_cfg_write and AVS_BYTEENABLE[1]) |=>
		BUS_WIDTH_4 == ($past(AVS_WRITEDATA[13:12]) == 2'h1))
		else $error("card bus width does not follow the written code");

	a_tx_stable: assert property (!(AVS_WRITE && !AVS_WAITREQUEST && hit_cfg) |=>
		$stable(TX_WIDTH))
		else $error("transmit width changed without a register write");

	a_tx_width: assert property ((s_cfg_write and AVS_BYTEENABLE[1]) |=>
		TX_WIDTH == $past(AVS_WRITEDATA[9:8]))
		else $error("transmit width differs from written value");

	a_rx_width: assert property ((s_cfg_write and AVS_BYTEENABLE[0]) |=>
		RX_WIDTH == $past(AVS_WRITEDATA[7:6]))
		else $error("receive width differs from written value");

	a_enable_hold: assert property (!IF_ENABLE |=>
		!BLOCK_START ##1 !XFER_ACTIVE)
		else $error("block issued while interface disabled");

	a_block_code: assert property (BLOCK_START |-> BLOCK_LEN_LOG2 != 4'h0)
		else $error("block started with reserved length code");

	a_chunk_step: assert property ((state_q == sdh_pkg::SDH_WAIT) && BLOCK_DONE
		&& !last && IF_ENABLE |=> remain == $past(remain) - $past(blk_len) ##0 BLOCK_START)
		else $error("remaining count not reduced by one block");

	// A new count write may legally start the next transfer one cycle later
	a_chunk_end: assert property (s_last_done |=> !XFER_ACTIVE && done_q
		&& !BLOCK_START)
		else $error("transfer did not end after last block");

	a_rsvd_zero: assert property (AVS_READ && !AVS_WAITREQUEST && hit_cfg
		|-> (AVS_READDATA & ~sdh_pkg::CFG_WMASK) == 32'h00000000)
		else $error("reserved configuration bits read nonzero");

	a_bus_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
		|=> !AVS_WAITREQUEST)
		else $error("slave did not answer after one wait cycle");

endmodule // sdh_cfg

// [src/sdh_chunk_cnt.sv]
/*
 * Remaining-byte counter of the block splitter: loads a total, steps down
 * by one block length per finished block, flags the last block.
 * Assumes load and step are never high together.
 */
`timescale 1ns/10ps
module sdh_chunk_cnt (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [31:0] load_val,
	input  wire logic        step,
	input  wire logic [3:0]  blk_log2,
	output logic      [31:0] remain,
	output logic             last
);
	logic [31:0] remain_q;
	logic [31:0] remain_d;
	logic [31:0] blk_len;

	always_comb begin
		blk_len  = 32'h00000001 << blk_log2;
		remain_d = remain_q;
		if (load) begin
			remain_d = load_val;
		end else if (step) begin
			// Never wraps below zero, even if a block finishes unexpectedly
			remain_d = (remain_q > blk_len) ? remain_q - blk_len : 32'h00000000;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			remain_q <= 32'h00000000;
		end else begin
			remain_q <= remain_d;
		end
	end

	assign remain = remain_q;
	assign last   = (remain_q <= blk_len);
endmodule // sdh_chunk_cnt

// [src/sdh_pkg.sv]
/*
 * Constants for the memory-card host configuration block: register map,
 * field positions, reset values and the block-splitter state type.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package sdh_pkg;

	// ***************************************************************
	// Register map
	// ***************************************************************
	localparam logic [7:0]  OFS_CFG    = 8'h10;
	localparam logic [7:0]  OFS_COUNT  = 8'h40;
	localparam logic [7:0]  OFS_STATUS = 8'h44;
	localparam logic [7:0]  OFS_REMAIN = 8'h48;

	// ***************************************************************
	// Configuration fields
	// ***************************************************************
	localparam int          BUSW_LSB   = 12;
	localparam int          TXW_LSB    = 8;
	localparam int          RXW_LSB    = 6;
	localparam int          ENA_BIT    = 5;
	localparam int          BLK_LSB    = 0;
	localparam logic [1:0]  BUSW_ONE   = 2'h0;
	localparam logic [1:0]  BUSW_FOUR  = 2'h1;
	localparam logic [3:0]  BLK_RSVD   = 4'h0;
	localparam logic [31:0] CFG_WMASK  = 32'h000033EF;
	localparam logic [31:0] CFG_RESET  = 32'h00000000;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;

	// ***************************************************************
	// Status fields
	// ***************************************************************
	localparam int          ST_ACTIVE  = 0;
	localparam int          ST_DONE    = 1;
	localparam int          ST_ERROR   = 2;
	localparam int          ST_ABORT   = 3;

	// ***************************************************************
	// Bus answer codes
	// ***************************************************************
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		SDH_IDLE  = 2'h0,
		SDH_ISSUE = 2'h1,
		SDH_WAIT  = 2'h3
	} sdh_state_type;

endpackage
